// ==== design/gain_blend.sv ====
// Linear blend of one gain between its set 1 and set 2 values.
// Assumes num <= den; den of zero selects set 1 outright.
`timescale 1ns/100ps
module gain_blend (
	input wire logic [15:0] set_a,
	input wire logic [15:0] set_b,
	input wire logic [15:0] num,
	input wire logic [15:0] den,
	output logic [15:0] value
);

	logic signed [16:0] diff;
	logic signed [33:0] prod;
	logic signed [33:0] quot;
	logic signed [33:0] sum;

	assign diff = $signed({1'b0, set_b}) - $signed({1'b0, set_a});
	assign prod = diff * $signed({1'b0, num});
	// Truncation toward zero keeps the result between the two sets
	assign quot = (den == 16'h0000) ? 34'sh0 :
		prod / $signed({18'h00000, den});
	assign sum = $signed({18'h00000, set_a}) + quot;
	assign value = sum[15:0];

endmodule

// ==== design/ms_counter.sv ====
// Millisecond elapsed-time counter with its own phase-aligned prescaler.
// Assumes start is a one-cycle pulse; len may change while counting.
`timescale 1ns/100ps
module ms_counter #(
	parameter int TICK_CYCLES = servo_gain_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [15:0] len,
	output logic [15:0] elapsed,
	output logic done
);

	logic [15:0] pre_q;
	logic [15:0] pre_d;
	logic [15:0] elapsed_q;
	logic [15:0] elapsed_d;
	logic tick;

	// Prescaler restarts with start so every wait is a whole number of ms
	assign tick = (pre_q == 16'(TICK_CYCLES - 1));
	assign pre_d = (start || tick) ? 16'h0000 : pre_q + 16'h0001;
	assign elapsed_d = start ? 16'h0000 :
		(tick && elapsed_q < len) ? elapsed_q + 16'h0001 : elapsed_q;
	assign done = (elapsed_q >= len);
	assign elapsed = elapsed_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= 16'h0000;
			elapsed_q <= 16'h0000;
		end else begin
			pre_q <= pre_d;
			elapsed_q <= elapsed_d;
		end
	end

endmodule

// ==== design/servo_gain_pkg.sv ====
// Constants shared by the gain set switcher and its helper modules.
// Assumes a 10 MHz control clock and a 5-bit word-addressed register port.
package servo_gain_pkg;

	// --------------------------------------------------------------------
	// Gain table layout
	// --------------------------------------------------------------------
	localparam int NUM_GAINS = 7;
	localparam int G_SPEED = 0;
	localparam int G_INTEG = 1;
	localparam int G_POS = 2;
	localparam int G_TORQ = 3;
	localparam int G_MFG = 4;
	localparam int G_MFC = 5;
	localparam int G_FRIC = 6;

	localparam logic [15:0] GAIN_RESET [NUM_GAINS] = '{16'h0190, 16'h07D0,
		16'h0190, 16'h0064, 16'h01F4, 16'h03E8, 16'h0064};
	localparam logic [15:0] GAIN_MIN [NUM_GAINS] = '{16'h000A, 16'h000F,
		16'h000A, 16'h0000, 16'h000A, 16'h01F4, 16'h000A};
	localparam logic [15:0] GAIN_MAX [NUM_GAINS] = '{16'h4E20, 16'hC800,
		16'h4E20, 16'hFFFF, 16'h4E20, 16'h07D0, 16'h03E8};

	// --------------------------------------------------------------------
	// Register map (word index)
	// --------------------------------------------------------------------
	localparam logic [4:0] ADDR_CONFIG = 5'h00;
	localparam logic [4:0] ADDR_SET_A = 5'h01;
	localparam logic [4:0] ADDR_SET_B = 5'h08;
	localparam logic [4:0] ADDR_WAIT_UP = 5'h0F;
	localparam logic [4:0] ADDR_WAIT_DOWN = 5'h10;
	localparam logic [4:0] ADDR_RAMP_UP = 5'h11;
	localparam logic [4:0] ADDR_RAMP_DOWN = 5'h12;
	localparam logic [4:0] ADDR_STATUS = 5'h13;

	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [15:0] TIME_RESET = 16'h0000;

	// --------------------------------------------------------------------
	// Configuration fields and status bits
	// --------------------------------------------------------------------
	localparam int MODE_LSB = 0;
	localparam int COND_LSB = 4;
	localparam logic [3:0] MODE_MANUAL = 4'h0;
	localparam logic [3:0] MODE_RESERVED = 4'h1;
	localparam logic [3:0] MODE_AUTO = 4'h2;
	localparam logic [3:0] COND_DONE_ON = 4'h0;
	localparam logic [3:0] COND_DONE_OFF = 4'h1;
	localparam logic [3:0] COND_NEAR_ON = 4'h2;
	localparam logic [3:0] COND_NEAR_OFF = 4'h3;
	localparam logic [3:0] COND_REF_IDLE = 4'h4;
	localparam logic [3:0] COND_REF_ON = 4'h5;

	localparam int STAT_SET_B = 0;
	localparam int STAT_WAITING = 1;
	localparam int STAT_RAMPING = 2;
	localparam int STAT_MF_SET_B = 3;

	// --------------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------------
	localparam int MS_NS = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== design/servo_gain_set_switcher.sv ====
// Gain set switcher: register file, switching sequencer, blended gains.
// Assumes all status inputs are synchronous to ref_clk.
`timescale 1ns/100ps
module servo_gain_set_switcher #(
	parameter int TICK_CYCLES = servo_gain_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic position_control,
	input wire logic gain_select,
	input wire logic position_complete_flag,
	input wire logic position_near_flag,
	input wire logic ref_filter_busy,
	input wire logic ref_input_on,
	input wire logic command_busy,
	input wire logic motor_stopped,
	output logic [15:0] eff_speed_gain,
	output logic [15:0] eff_speed_integral,
	output logic [15:0] eff_position_gain,
	output logic [15:0] eff_torque_filter,
	output logic [15:0] eff_model_follow_gain,
	output logic [15:0] eff_model_follow_comp,
	output logic [15:0] eff_friction_gain,
	output logic gain_set_b,
	output logic switch_busy
);

	typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_RAMP} sw_state_t;

	localparam int NG = servo_gain_pkg::NUM_GAINS;

	// --------------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------------
	logic [15:0] cfg_q;
	logic [15:0] set_a_q [NG];
	logic [15:0] set_b_q [NG];
	logic [15:0] eff_q [NG];
	logic [15:0] blend [NG];
	logic [15:0] wait_up_q;
	logic [15:0] wait_down_q;
	logic [15:0] ramp_up_q;
	logic [15:0] ramp_down_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	sw_state_t state_q;
	sw_state_t state_d;
	logic cur_b_q;
	logic cur_b_d;
	logic tgt_b_q;
	logic tgt_b_d;
	logic mf_b_q;
	logic mf_b_d;

	function automatic logic in_range(input int idx, input logic [15:0] v);
		in_range = (v >= servo_gain_pkg::GAIN_MIN[idx]) &&
			(v <= servo_gain_pkg::GAIN_MAX[idx]);
	endfunction

	function automatic logic hit(input logic [4:0] a, input logic [4:0] base,
		input int idx);
		hit = (a == 5'(base + 5'(idx)));
	endfunction

	// --------------------------------------------------------------------
	// Configuration decode
	// --------------------------------------------------------------------
	wire [3:0] mode = cfg_q[servo_gain_pkg::MODE_LSB +: 4];
	wire [3:0] cond_sel = cfg_q[servo_gain_pkg::COND_LSB +: 4];
	wire [3:0] wr_mode = reg_wdata[servo_gain_pkg::MODE_LSB +: 4];
	wire [3:0] wr_cond = reg_wdata[servo_gain_pkg::COND_LSB +: 4];
	wire manual = (mode == servo_gain_pkg::MODE_MANUAL);
	wire automatic_mode = (mode == servo_gain_pkg::MODE_AUTO);
	// automatic switching is enabled only under position control
	wire auto_pos = automatic_mode && position_control;
	// reserved mode and unknown conditions are refused
	wire cfg_ok = (wr_mode == servo_gain_pkg::MODE_MANUAL ||
		wr_mode == servo_gain_pkg::MODE_AUTO) &&
		(wr_cond <= servo_gain_pkg::COND_REF_ON);
	wire cfg_wr = reg_wr && reg_addr == servo_gain_pkg::ADDR_CONFIG && cfg_ok;

	wire cond_a =
		(cond_sel == servo_gain_pkg::COND_DONE_ON) ? position_complete_flag :
		(cond_sel == servo_gain_pkg::COND_DONE_OFF) ? !position_complete_flag :
		(cond_sel == servo_gain_pkg::COND_NEAR_ON) ? position_near_flag :
		(cond_sel == servo_gain_pkg::COND_NEAR_OFF) ? !position_near_flag :
		(cond_sel == servo_gain_pkg::COND_REF_IDLE) ?
			(!ref_filter_busy && !ref_input_on) : ref_input_on;
	// odd condition digits fix set 2 outside position control
	wire fixed_b = cond_sel[0];

	// --------------------------------------------------------------------
	// Switching sequencer
	// --------------------------------------------------------------------
	logic cnt_start;
	logic [15:0] cnt_len;
	logic [15:0] cnt_elapsed;
	logic cnt_done;

	// condition true heads for set 2
	// condition false heads back to set 1
	wire desired_b = cond_a;
	wire [15:0] wait_len = desired_b ? wait_up_q : wait_down_q;
	wire [15:0] ramp_len = tgt_b_q ? ramp_up_q : ramp_down_q;
	wire go_wait = auto_pos && state_q == SW_IDLE && desired_b != cur_b_q;
	wire go_ramp = auto_pos && state_q == SW_WAIT && desired_b != cur_b_q &&
		cnt_done;

	// the counter times the wait first, then the ramp
	assign cnt_start = go_wait || go_ramp;
	assign cnt_len = (state_q == SW_RAMP) ? ramp_len : wait_len;

	always_comb begin
		state_d = state_q;
		cur_b_d = cur_b_q;
		tgt_b_d = tgt_b_q;
		if (manual) begin
			// command bit picks the set directly
			state_d = SW_IDLE;
			cur_b_d = gain_select;
		end else if (!auto_pos) begin
			state_d = SW_IDLE;
			cur_b_d = fixed_b;
		end else begin
			unique case (state_q)
				SW_IDLE: begin
					if (go_wait) begin
						state_d = SW_WAIT;
						tgt_b_d = desired_b;
					end
				end
				SW_WAIT: begin
					// a reverted condition drops the pending wait
					if (desired_b == cur_b_q) begin
						state_d = SW_IDLE;
					end else if (go_ramp) begin
						state_d = SW_RAMP;
					end
				end
				SW_RAMP: begin
					// zero ramp finishes on its first cycle
					if (cnt_done) begin
						state_d = SW_IDLE;
						cur_b_d = tgt_b_q;
					end
				end
			endcase
		end
	end

	// model-follow pair needs manual mode, no command and a stop
	assign mf_b_d = (manual && !command_busy && motor_stopped) ?
		gain_select : mf_b_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= SW_IDLE;
			cur_b_q <= 1'b0;
			tgt_b_q <= 1'b0;
			mf_b_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cur_b_q <= cur_b_d;
			tgt_b_q <= tgt_b_d;
			mf_b_q <= mf_b_d;
		end
	end

	ms_counter #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(cnt_start),
		.len(cnt_len),
		.elapsed(cnt_elapsed),
		.done(cnt_done)
	);

	// --------------------------------------------------------------------
	// Blend weights
	// --------------------------------------------------------------------
	// weight toward set 2 grows or shrinks linearly with elapsed ms
	wire ramping = (state_q == SW_RAMP) && ramp_len != 16'h0000;
	wire [15:0] w_den = ramping ? ramp_len : 16'h0001;
	wire [15:0] w_num = ramping ?
		(tgt_b_q ? cnt_elapsed : ramp_len - cnt_elapsed) :
		{15'h0000, cur_b_q};
	wire [15:0] mf_num = {15'h0000, mf_b_q};

	// --------------------------------------------------------------------
	// Register file and blended gains
	// --------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : gen_gain
			wire pair = (g == servo_gain_pkg::G_MFG) ||
				(g == servo_gain_pkg::G_MFC);
			wire wr_a = reg_wr && in_range(g, reg_wdata) &&
				hit(reg_addr, servo_gain_pkg::ADDR_SET_A, g);
			wire wr_b = reg_wr && in_range(g, reg_wdata) &&
				hit(reg_addr, servo_gain_pkg::ADDR_SET_B, g);

			gain_blend u_blend (
				.set_a(set_a_q[g]),
				.set_b(set_b_q[g]),
				.num(pair ? mf_num : w_num),
				.den(pair ? 16'h0001 : w_den),
				.value(blend[g])
			);

			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					set_a_q[g] <= servo_gain_pkg::GAIN_RESET[g];
					set_b_q[g] <= servo_gain_pkg::GAIN_RESET[g];
					eff_q[g] <= servo_gain_pkg::GAIN_RESET[g];
				end else begin
					if (wr_a) begin
						set_a_q[g] <= reg_wdata;
					end
					if (wr_b) begin
						set_b_q[g] <= reg_wdata;
					end
					eff_q[g] <= blend[g];
				end
			end
		end
	endgenerate

	wire [15:0] status = {12'h000, mf_b_q, state_q == SW_RAMP,
		state_q == SW_WAIT, cur_b_q};

	always_comb begin
		rdata_d = 16'h0000;
		for (int i = 0; i < NG; i++) begin
			if (hit(reg_addr, servo_gain_pkg::ADDR_SET_A, i)) begin
				rdata_d = set_a_q[i];
			end
			if (hit(reg_addr, servo_gain_pkg::ADDR_SET_B, i)) begin
				rdata_d = set_b_q[i];
			end
		end
		unique case (reg_addr)
			servo_gain_pkg::ADDR_CONFIG: rdata_d = cfg_q;
			servo_gain_pkg::ADDR_WAIT_UP: rdata_d = wait_up_q;
			servo_gain_pkg::ADDR_WAIT_DOWN: rdata_d = wait_down_q;
			servo_gain_pkg::ADDR_RAMP_UP: rdata_d = ramp_up_q;
			servo_gain_pkg::ADDR_RAMP_DOWN: rdata_d = ramp_down_q;
			servo_gain_pkg::ADDR_STATUS: rdata_d = status;
			default: begin
			end
		endcase
		if (!reg_rd) begin
			rdata_d = 16'h0000;
		end
	end

	// full 16-bit time ranges, no check needed
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= servo_gain_pkg::CONFIG_RESET;
			wait_up_q <= servo_gain_pkg::TIME_RESET;
			wait_down_q <= servo_gain_pkg::TIME_RESET;
			ramp_up_q <= servo_gain_pkg::TIME_RESET;
			ramp_down_q <= servo_gain_pkg::TIME_RESET;
			rdata_q <= 16'h0000;
		end else begin
			if (cfg_wr) begin
				cfg_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == servo_gain_pkg::ADDR_WAIT_UP) begin
				wait_up_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == servo_gain_pkg::ADDR_WAIT_DOWN) begin
				wait_down_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == servo_gain_pkg::ADDR_RAMP_UP) begin
				ramp_up_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == servo_gain_pkg::ADDR_RAMP_DOWN) begin
				ramp_down_q <= reg_wdata;
			end
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign eff_speed_gain = eff_q[servo_gain_pkg::G_SPEED];
	assign eff_speed_integral = eff_q[servo_gain_pkg::G_INTEG];
	assign eff_position_gain = eff_q[servo_gain_pkg::G_POS];
	assign eff_torque_filter = eff_q[servo_gain_pkg::G_TORQ];
	assign eff_model_follow_gain = eff_q[servo_gain_pkg::G_MFG];
	assign eff_model_follow_comp = eff_q[servo_gain_pkg::G_MFC];
	assign eff_friction_gain = eff_q[servo_gain_pkg::G_FRIC];
	assign gain_set_b = cur_b_q;
	assign switch_busy = (state_q != SW_IDLE);

	// --------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_manual_select: assert property (
		(manual && gain_select && !reg_wr)[*2] |=>
		eff_speed_gain == set_b_q[servo_gain_pkg::G_SPEED])
		else $error("manual select did not apply set 2");
	a_auto_only_pos: assert property (
		(automatic_mode && !position_control) |=> state_q == SW_IDLE)
		else $error("automatic switching outside position control");
	a_fixed_set: assert property (
		(automatic_mode && !position_control) |=> cur_b_q == $past(fixed_b))
		else $error("fixed set outside position control wrong");
	a_wait_hold: assert property (
		(state_q == SW_WAIT && !cnt_done) |=> state_q != SW_RAMP)
		else $error("ramp started before wait expired");
	a_wait_restart: assert property (
		(state_q == SW_WAIT && auto_pos && desired_b == cur_b_q) |=>
		state_q == SW_IDLE)
		else $error("pending wait not dropped");
	a_ramp_end: assert property (
		(state_q == SW_RAMP && auto_pos && cnt_done) |=>
		state_q == SW_IDLE && cur_b_q == $past(tgt_b_q))
		else $error("ramp did not settle on target");
	a_zero_ramp: assert property (
		(state_q == SW_RAMP && auto_pos && ramp_len == 16'h0000) |->
		cnt_done ##1 state_q == SW_IDLE)
		else $error("zero ramp took more than one cycle");
	a_range_reject: assert property (
		(reg_wr && reg_addr == servo_gain_pkg::ADDR_SET_A &&
		reg_wdata < 16'h000A) |=> $stable(set_a_q[servo_gain_pkg::G_SPEED]))
		else $error("out-of-range speed gain accepted");
	a_reserved_mode: assert property (
		(reg_wr && reg_addr == servo_gain_pkg::ADDR_CONFIG &&
		wr_mode == servo_gain_pkg::MODE_RESERVED) |=> $stable(cfg_q))
		else $error("reserved mode accepted");
	a_mf_hold: assert property (
		(command_busy || !motor_stopped) |=> $stable(mf_b_q))
		else $error("model-follow pair switched while busy");

	c_full_ramp: cover property (
		state_q == SW_WAIT ##1 state_q == SW_RAMP [*3] ##1 state_q == SW_IDLE);
	c_wait_abort: cover property (
		state_q == SW_WAIT ##1 state_q == SW_IDLE && !$past(cnt_done));
	c_manual_toggle: cover property (
		manual && !cur_b_q ##1 manual && cur_b_q);

endmodule

// ==== verification/host_model.sv ====
// Host controller model: sends commands carrying the gain select option bit.
// Assumes the bench pulses cmd_send for one cycle per command.
`timescale 1ns/100ps
module host_model (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cmd_send,
	input wire logic cmd_gsel,
	input wire logic [7:0] busy_len,
	output logic gain_select,
	output logic command_busy,
	output logic motor_stopped
);
	// ------------------------------------------------------------------
	// Command execution
	// ------------------------------------------------------------------
	logic [7:0] left_q;

	// option bit per command
	// Busy and stopped stay consistent, so the pair can be stalled
	// busy and stopped status
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gain_select <= 1'h0;
			left_q <= 8'h00;
			command_busy <= 1'h0;
			motor_stopped <= 1'h1;
		end else if (cmd_send) begin
			gain_select <= cmd_gsel;
			left_q <= busy_len;
			command_busy <= busy_len != 8'h00;
			motor_stopped <= busy_len == 8'h00;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
			command_busy <= left_q != 8'h01;
			motor_stopped <= left_q == 8'h01;
		end
	end
endmodule

// ==== verification/tb_top.sv ====
// Testbench for the gain set switcher: registers, manual and auto switching.
// Assumes the host model drives the option bit and the command status.
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
	fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module tb_top;
	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	localparam int T = 4;
	logic ref_clk, rstn, reg_wr, reg_rd, position_control, gain_select;
	logic position_complete_flag, position_near_flag, ref_filter_busy;
	logic ref_input_on, command_busy, motor_stopped, gain_set_b, switch_busy;
	logic cmd_send, cmd_gsel;
	logic [7:0] busy_len;
	logic [4:0] reg_addr, a;
	logic [15:0] reg_wdata, reg_rdata, rv, prev, rs, lo, hi;
	logic [15:0] eff_speed_gain, eff_speed_integral, eff_position_gain;
	logic [15:0] eff_torque_filter, eff_model_follow_gain;
	logic [15:0] eff_model_follow_comp, eff_friction_gain;
	int fail_count, n_tests, n, bad;

	servo_gain_set_switcher #(.TICK_CYCLES(T)) dut (.ref_clk, .rstn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.position_control, .gain_select, .position_complete_flag,
		.position_near_flag, .ref_filter_busy, .ref_input_on,
		.command_busy, .motor_stopped, .eff_speed_gain, .eff_speed_integral,
		.eff_position_gain, .eff_torque_filter, .eff_model_follow_gain,
		.eff_model_follow_comp, .eff_friction_gain, .gain_set_b,
		.switch_busy);
	host_model host (.ref_clk, .rstn, .cmd_send, .cmd_gsel, .busy_len,
		.gain_select, .command_busy, .motor_stopped);

	always #50 ref_clk = ~ref_clk;

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task wr(input logic [4:0] ad, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task rchk(input string name, input logic [4:0] ad, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 rv = reg_rdata;
		`CHECK(name, e, rv)
	endtask
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task wait_set(input logic e, input int maxc, input string name);
		#1;
		n = 0;
		while (gain_set_b !== e && n < maxc) begin
			cyc(1);
			n++;
		end
		`CHECK(name, e, gain_set_b)
	endtask
	// Drives the inputs that condition c looks at and clears the others
	task set_cond(input int c, input logic v);
		@(posedge ref_clk);
		position_complete_flag <= (c == 0) ? v : (c == 1) ? !v : 1'h0;
		position_near_flag <= (c == 2) ? v : (c == 3) ? !v : 1'h0;
		ref_filter_busy <= 1'h0;
		ref_input_on <= (c == 4) ? !v : (c == 5) ? v : 1'h0;
	endtask
	task cmd(input logic g, input logic [7:0] len);
		@(posedge ref_clk);
		cmd_send <= 1'h1;
		cmd_gsel <= g;
		busy_len <= len;
		@(posedge ref_clk);
		cmd_send <= 1'h0;
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{ref_clk, rstn, reg_wr, reg_rd, position_control, cmd_send} = 6'h00;
		{position_complete_flag, position_near_flag} = 2'h0;
		{ref_filter_busy, ref_input_on, cmd_gsel} = 3'h0;
		{reg_addr, reg_wdata, busy_len} = 29'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'h1;
		`CHECK("eff speed reset", 16'h0190, eff_speed_gain)
		`CHECK("eff comp reset", 16'h03E8, eff_model_follow_comp)
		for (int i = 0; i < servo_gain_pkg::NUM_GAINS; i++) begin
			a = 5'h01 + 5'(i);
			rs = servo_gain_pkg::GAIN_RESET[i];
			lo = servo_gain_pkg::GAIN_MIN[i];
			hi = servo_gain_pkg::GAIN_MAX[i];
			rchk("set2 reset", a + 5'h07, rs);
			if (hi != 16'hFFFF)
				wr(a, hi + 16'h0001);
			if (lo != 16'h0000)
				wr(a, lo - 16'h0001);
			rchk("range refused", a, rs);
			wr(a, hi);
			rchk("range max", a, hi);
		end
		`CHECK("eff speed immediate", 16'h4E20, eff_speed_gain)
		for (int i = 15; i < 19; i++) begin
			rchk("time reset", 5'(i), 16'h0000);
		end
		wr(5'h03, 16'h0064);
		wr(5'h0A, 16'h01F4);
		wr(5'h08, 16'h0800);
		wr(5'h0C, 16'h0300);
		wr(5'h00, 16'h0120);
		wr(5'h00, 16'h0001);
		wr(5'h00, 16'h0062);
		rchk("config refused", 5'h00, 16'h0120);
		rchk("unmapped", 5'h1F, 16'h0000);
		wr(5'h00, 16'h0000);
		// Manual select while a command runs, then idle
		cmd(1'h1, 8'h0A);
		cyc(3);
		`CHECK("manual set2", 16'h0800, eff_speed_gain)
		`CHECK("mf held busy", 16'h4E20, eff_model_follow_gain)
		cyc(12);
		`CHECK("mf switched", 16'h0300, eff_model_follow_gain)
		`CHECK("manual flag", 1'h1, gain_set_b)
		cmd(1'h0, 8'h00);
		cyc(4);
		`CHECK("manual set1", 16'h4E20, eff_speed_gain)
		for (int c = 0; c < 6; c++) begin
			wr(5'h00, {8'h00, 4'(c), 4'h2});
			set_cond(c, 1'h1);
			cyc(4);
			`CHECK("fixed set", 1'(c % 2), gain_set_b)
		end
		@(posedge ref_clk);
		position_control <= 1'h1;
		for (int c = 0; c < 6; c++) begin
			set_cond(c, 1'h0);
			wr(5'h00, {8'h00, 4'(c), 4'h2});
			wait_set(1'h0, 12, "auto idle");
			set_cond(c, 1'h1);
			wait_set(1'h1, 8, "auto up");
			set_cond(c, 1'h0);
			wait_set(1'h0, 8, "auto down");
		end
		wr(5'h00, 16'h0002);
		wr(5'h0F, 16'h0001);
		wr(5'h11, 16'h0002);
		set_cond(0, 1'h1);
		n = 0;
		while (eff_position_gain === 16'h0064 && n < 40) begin
			cyc(1);
			n++;
		end
		`CHECK("wait span", 1'h1, n >= T)
		prev = eff_position_gain;
		bad = 0;
		while (switch_busy === 1'h1 && n < 60) begin
			cyc(1);
			n++;
			if (eff_position_gain < prev || eff_position_gain > 16'h01F4)
				bad++;
			prev = eff_position_gain;
		end
		`CHECK("ramp monotone", 0, bad)
		`CHECK("ramp span", 1'h1, n <= 3 * T + 5)
		wait_set(1'h1, 4, "ramp end");
		`CHECK("ramp target", 16'h01F4, eff_position_gain)
		rchk("status set2", 5'h13, 16'h0001);
		set_cond(0, 1'h0);
		wait_set(1'h0, 8, "down zero");
		// Effective gains lag the settled flag by one cycle
		cyc(1);
		`CHECK("down target", 16'h0064, eff_position_gain)
		set_cond(0, 1'h1);
		cyc(2);
		`CHECK("waiting", 1'h1, switch_busy)
		set_cond(0, 1'h0);
		cyc(12);
		`CHECK("revert set", 1'h0, gain_set_b)
		`CHECK("revert idle", 1'h0, switch_busy)
		@(posedge ref_clk);
		ref_filter_busy <= 1'h1;
		wr(5'h00, 16'h0042);
		cyc(20);
		`CHECK("filter busy", 1'h0, gain_set_b)
		@(posedge ref_clk);
		ref_filter_busy <= 1'h0;
		wait_set(1'h1, 20, "filter idle");
		print_verdict();
	end

	// Whole run is a few hundred cycles; this leaves ample slack
	initial begin
		#(100 * 20000);
		fail_count++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
